// file: hdl/io_ctrl_defines.vh
// Purpose: constants for the global I/O control register bank
// Assumes: byte-addressed register access port, 16-bit address
// Notes:   offsets are byte addresses; 32-bit register spans four bytes
`ifndef IO_CTRL_DEFINES_VH
`define IO_CTRL_DEFINES_VH
`define ADDR_SERIAL_IO_CTRL   16'h0100
`define ADDR_OUT_CLK_CTRL     16'h0103
`define ADDR_INBAND_CTRL_B0   16'h0104
`define ADDR_INBAND_CTRL_B3   16'h0107
`define SIO_PREAMBLE_SUPP_BIT 2
`define SIO_AUTO_EDGE_BIT     1
`define SIO_MANUAL_EDGE_BIT   0
`define SIO_RESET             8'h42
`define OCK_ENABLE_BIT        1
`define OCK_FREQ_BIT          0
`define OCK_RESET             8'h02
`define OCK_WR_MASK           8'h1F
`define IBC_ENABLE_BIT        31
`define IBC_DA_CHECK_BIT      30
`define IBC_SM_RESET_BIT      29
`define IBC_PRIO_MSB          23
`define IBC_PRIO_LSB          22
`define IBC_PORT_MSB          18
`define IBC_PORT_LSB          16
`define IBC_TYPE_MSB          15
`define IBC_TYPE_LSB          0
`define IBC_PRIO_RESET        2'h1
`define IBC_PORT_RESET        3'h5
`define IBC_TYPE_RESET        16'h40FE
`define IBC_LANE2_WR_MASK     8'hC7
`define IBC_LANE3_WR_MASK     8'hE0
`define SPI_FAST_HZ           25000000
`define SYS_CLK_HZ            50000000
`endif

// file: hdl/global_io_control_regs.v
// Purpose: global I/O control registers: serial management options,
//          reference clock output control and in-band management settings
// Assumes: byte-wide register port synchronous to clk_i, one access per cycle
// Notes:   register outputs feed the serial, clock and in-band blocks
`timescale 1ns/10ps
`include "io_ctrl_defines.vh"

module global_io_control_regs #(
    parameter SYS_HZ = `SYS_CLK_HZ
) (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        inband_enable_strap_pin_i,
    input  wire [15:0] reg_addr_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [7:0]  reg_wdata_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        spi_clk_fast_i,
    input  wire        frame_valid_i,
    input  wire        frame_da_match_i,
    input  wire        frame_is_mgmt_type_i,
    output wire [15:0] frame_type_tag_o,
    output wire        frame_accept_o,
    output wire        mgmt_preamble_required_o,
    output wire        spi_out_rising_edge_o,
    output wire        ref_clock_output_pin_o,
    output wire        ref_clock_output_oe_n_o,
    output wire        inband_mgmt_enable_o,
    output wire        inband_sm_reset_o,
    output wire        response_allowed_o,
    output wire [1:0]  response_queue_o,
    output wire [2:0]  inband_port_o,
    output wire        inband_port_valid_o
);

    reg  [7:0]  sio_reg;
    reg  [7:0]  ock_reg;
    reg  [31:0] ibc_reg;
    reg         strap_done_reg;
    reg         sm_reset_reg;
    reg         ref_clk_reg;
    reg         ref_clk_next;
    reg  [31:0] ibc_next;
    wire [3:0]  lane_hit;
    integer     n;

    // byte lane within the 32-bit in-band register, or 3'h4 when not addressed
    function [2:0] ibc_lane;
        input [15:0] addr;
        begin
            if (addr >= `ADDR_INBAND_CTRL_B0 && addr <= `ADDR_INBAND_CTRL_B3) begin
                ibc_lane = {1'b0, addr[1:0]};
            end else begin
                ibc_lane = 3'h4;
            end
        end
    endfunction

    wire [2:0] wr_lane = ibc_lane(reg_addr_i);

    // writable bits of each byte lane; reserved read-only bits stay zero
    function [7:0] ibc_lane_mask;
        input [1:0] lane;
        begin
            case (lane)
                2'h2:    ibc_lane_mask = `IBC_LANE2_WR_MASK;
                2'h3:    ibc_lane_mask = `IBC_LANE3_WR_MASK;
                default: ibc_lane_mask = 8'hFF;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            localparam [2:0] LANE = g;
            assign lane_hit[g] = reg_wr_i & (wr_lane == LANE);
        end
    endgenerate

    // next in-band word; the reset-request bit falls unless it is rewritten
    always @* begin
        ibc_next = ibc_reg;
        ibc_next[`IBC_SM_RESET_BIT] = 1'b0;
        for (n = 0; n < 4; n = n + 1) begin
            if (lane_hit[n]) begin
                ibc_next[n*8 +: 8] = reg_wdata_i & ibc_lane_mask(n[1:0]);
            end
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sio_reg        <= `SIO_RESET;
            ock_reg        <= `OCK_RESET;
            ibc_reg        <= {8'h00, `IBC_PRIO_RESET, 3'h0,
                               `IBC_PORT_RESET, `IBC_TYPE_RESET};
            strap_done_reg <= 1'b0;
            sm_reset_reg   <= 1'b0;
        end else begin
            ibc_reg      <= ibc_next;
            // the reset pulse lives one cycle, like the bit that requested it
            sm_reset_reg <= lane_hit[3] & reg_wdata_i[`IBC_SM_RESET_BIT - 24];
            // strap is caught on the first clock after reset release and wins
            // over a write to the top byte in that same cycle
            if (!strap_done_reg) begin
                strap_done_reg           <= 1'b1;
                ibc_reg[`IBC_ENABLE_BIT] <= inband_enable_strap_pin_i;
            end
            if (reg_wr_i) begin
                if (reg_addr_i == `ADDR_SERIAL_IO_CTRL) begin
                    sio_reg <= reg_wdata_i;
                end
                if (reg_addr_i == `ADDR_OUT_CLK_CTRL) begin
                    ock_reg <= reg_wdata_i & `OCK_WR_MASK;
                end
            end
        end
    end

    always @* begin
        reg_rdata_o = 8'h00;
        if (reg_rd_i) begin
            case (wr_lane)
                3'h0: reg_rdata_o = ibc_reg[7:0];
                3'h1: reg_rdata_o = ibc_reg[15:8];
                3'h2: reg_rdata_o = ibc_reg[23:16];
                3'h3: reg_rdata_o = ibc_reg[31:24];
                default: begin
                    if (reg_addr_i == `ADDR_SERIAL_IO_CTRL) begin
                        reg_rdata_o = sio_reg;
                    end else if (reg_addr_i == `ADDR_OUT_CLK_CTRL) begin
                        reg_rdata_o = ock_reg;
                    end
                end
            endcase
        end
    end

    // while enabled the pin toggles every clock, 25 MHz from the 50 MHz system clock;
    // 125 MHz cannot be made here, so the frequency bit is only stored
    always @* begin
        ref_clk_next = ~ref_clk_reg;
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_clk_reg <= 1'b0;
        end else begin
            ref_clk_reg <= ref_clk_next;
        end
    end

    assign ref_clock_output_pin_o   = ock_reg[`OCK_ENABLE_BIT] & ref_clk_reg;
    assign ref_clock_output_oe_n_o  = ~ock_reg[`OCK_ENABLE_BIT];

    // only the management serial path sees this; SPI/I2C do not use it
    assign mgmt_preamble_required_o = ~sio_reg[`SIO_PREAMBLE_SUPP_BIT];
    assign spi_out_rising_edge_o    = sio_reg[`SIO_AUTO_EDGE_BIT] ? spi_clk_fast_i
                                    : sio_reg[`SIO_MANUAL_EDGE_BIT];

    assign inband_mgmt_enable_o = ibc_reg[`IBC_ENABLE_BIT];
    assign inband_sm_reset_o    = sm_reset_reg;
    assign frame_type_tag_o     = ibc_reg[`IBC_TYPE_MSB:`IBC_TYPE_LSB];
    assign frame_accept_o       = frame_valid_i & ibc_reg[`IBC_ENABLE_BIT]
                                & frame_is_mgmt_type_i
                                & (~ibc_reg[`IBC_DA_CHECK_BIT] | frame_da_match_i);
    assign response_allowed_o   = ibc_reg[`IBC_ENABLE_BIT];
    assign response_queue_o     = ibc_reg[`IBC_PRIO_MSB:`IBC_PRIO_LSB];
    assign inband_port_o        = ibc_reg[`IBC_PORT_MSB:`IBC_PORT_LSB];
    assign inband_port_valid_o  = (ibc_reg[`IBC_PORT_MSB:`IBC_PORT_LSB] <= 3'h5);

endmodule

// file: tb/io_ctrl_chk.sv
// Purpose: port checker for the global I/O control registers
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to the design below the module
`timescale 1ns/10ps
module io_ctrl_chk (
    input wire       clk_i, resetn_i, reg_wr_i, spi_clk_fast_i, frame_valid_i,
    input wire       frame_is_mgmt_type_i, mgmt_preamble_required_o, spi_out_rising_edge_o,
    input wire       ref_clock_output_oe_n_o, inband_mgmt_enable_o, inband_sm_reset_o,
    input wire       frame_accept_o, inband_port_valid_o,
    input wire [15:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [1:0] response_queue_o,
    input wire [2:0] inband_port_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire w0 = reg_wr_i && reg_addr_i == 16'h0100;
    wire w3 = reg_wr_i && reg_addr_i == 16'h0103;
    wire w6 = reg_wr_i && reg_addr_i == 16'h0106;
    wire w7 = reg_wr_i && reg_addr_i == 16'h0107 && reg_wdata_i[5];
    property p_pre; w0 |=> mgmt_preamble_required_o == !$past(reg_wdata_i[2]); endproperty
    a_pre: assert property (p_pre) else $error("preamble flag wrong");
    property p_auto; w0 && reg_wdata_i[1] |=> spi_out_rising_edge_o == spi_clk_fast_i; endproperty
    a_auto: assert property (p_auto) else $error("auto edge wrong");
    property p_man; w0 && !reg_wdata_i[1] |=> spi_out_rising_edge_o == $past(reg_wdata_i[0]);
    endproperty
    a_man: assert property (p_man) else $error("manual edge wrong");
    property p_oe; w3 |=> ref_clock_output_oe_n_o == !$past(reg_wdata_i[1]); endproperty
    a_oe: assert property (p_oe) else $error("clock enable wrong");
    property p_scr; w7 |=> inband_sm_reset_o; endproperty
    a_scr: assert property (p_scr) else $error("sm reset missing");
    property p_pls; inband_sm_reset_o |-> $past(w7); endproperty
    a_pls: assert property (p_pls) else $error("sm reset stuck");
    property p_acc; frame_accept_o |-> frame_valid_i && inband_mgmt_enable_o && frame_is_mgmt_type_i;
    endproperty
    a_acc: assert property (p_acc) else $error("frame accepted wrongly");
    property p_port; inband_port_valid_o == (inband_port_o <= 3'h5); endproperty
    a_port: assert property (p_port) else $error("port valid wrong");
    property p_prio; w6 |=> response_queue_o == $past(reg_wdata_i[7:6]); endproperty
    a_prio: assert property (p_prio) else $error("queue wrong");
    c_scr: cover property (inband_sm_reset_o);
    c_acc: cover property (frame_accept_o);
    c_man: cover property (w0 && !reg_wdata_i[1]);
endmodule
bind global_io_control_regs io_ctrl_chk u_chk (.*);

// file: tb/mgmt_host_model.sv
// Purpose: management host driving the byte register port
// Assumes: requests launched after a rising edge, taken at the next
// Notes:   write data is inverted once released so stale bytes never match
`timescale 1ns/10ps
module mgmt_host_model (
    input  wire       clk_i,
    input  wire [7:0] rdata_i,
    output reg [15:0] addr_o = 16'h0000,
    output reg        wr_o = 1'b0,
    output reg        rd_o = 1'b0,
    output reg [7:0]  wdata_o = 8'h00
);
    task wr(input [15:0] a, input [7:0] d); begin
        @(posedge clk_i); addr_o <= a; wdata_o <= d; wr_o <= 1'b1;
        @(posedge clk_i); wr_o <= 1'b0; wdata_o <= ~d;
    end endtask
    task rd(input [15:0] a, output [7:0] d); begin
        @(posedge clk_i); addr_o <= a; rd_o <= 1'b1;
        @(posedge clk_i); d = rdata_i; rd_o <= 1'b0;
    end endtask
    // merge into the read value so reserved bits keep their contents
    task rmw(input [15:0] a, input [7:0] s); reg [7:0] v; begin
        rd(a, v); wr(a, v | s);
    end endtask
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the global I/O control registers
// Assumes: strap pin high through the first reset, driven low before the second
// Notes:   random bytes and frame qualifiers come from an lfsr
`timescale 1ns/10ps
module tb_top;
    reg clk_i = 1'b0, resetn_i = 1'b0, inband_enable_strap_pin_i = 1'b1, spi_clk_fast_i = 1'b0;
    reg frame_valid_i = 1'b0, frame_da_match_i = 1'b0, frame_is_mgmt_type_i = 1'b0;
    wire [15:0] reg_addr_i, frame_type_tag_o;
    wire [7:0] reg_wdata_i, reg_rdata_o;
    wire reg_wr_i, reg_rd_i, frame_accept_o, mgmt_preamble_required_o, spi_out_rising_edge_o;
    wire ref_clock_output_pin_o, ref_clock_output_oe_n_o, inband_mgmt_enable_o;
    wire inband_sm_reset_o, response_allowed_o, inband_port_valid_o;
    wire [1:0] response_queue_o;
    wire [2:0] inband_port_o;
    integer errors = 0, samples_checked = 0, i, k;
    int m [0:8] = '{8'h42, 0, 0, 8'h02, 8'hFE, 8'h40, 8'h45, 8'h80, 0};
    int wm [0:8] = '{8'hFF, 0, 0, 8'h1F, 8'hFF, 8'hFF, 8'hC7, 8'hC0, 0};
    reg [15:0] sd = 16'd54589;
    reg [7:0] v;
    always #10 clk_i = ~clk_i;
    global_io_control_regs u_dut (.*);
    mgmt_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
                          .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
    function [15:0] nx(input [15:0] s); nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]}; endfunction
    task chk(input [15:0] seen, input [15:0] exp); begin
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end endtask
    task give_verdict; begin
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end endtask
    initial begin #100000; errors = errors + 1; give_verdict; end
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        for (k = 0; k < 9; k++) begin host.rd(16'h0100 + k, v); chk(v, m[k]); end
        for (i = 0; i < 80; i++) begin
            sd = nx(sd); k = sd % 9; sd = nx(sd);
            @(posedge clk_i);
            {spi_clk_fast_i, frame_valid_i, frame_da_match_i, frame_is_mgmt_type_i} <= sd[11:8];
            host.wr(16'h0100 + k, sd[7:0]);
            m[k] = sd[7:0] & wm[k];
            #1 chk(inband_sm_reset_o, k == 7 && sd[5]);
            chk(mgmt_preamble_required_o, !m[0][2]);
            chk(spi_out_rising_edge_o, m[0][1] ? spi_clk_fast_i : m[0][0]);
            chk(ref_clock_output_oe_n_o, !m[3][1]);
            chk(response_allowed_o, m[7][7]);
            chk({inband_mgmt_enable_o, response_queue_o, inband_port_o}, {m[7][7], m[6][7:6], m[6][2:0]});
            chk(inband_port_valid_o, m[6][2:0] < 6);
            chk(frame_type_tag_o, {m[5][7:0], m[4][7:0]});
            chk(frame_accept_o, frame_valid_i && m[7][7] && frame_is_mgmt_type_i
                && (!m[7][6] || frame_da_match_i));
            @(negedge clk_i) v = ref_clock_output_pin_o;
            @(negedge clk_i) chk(ref_clock_output_pin_o, m[3][1] ? !v[0] : 1'b0);
            host.rd(16'h0100 + k, v); chk(v, m[k]);
        end
        host.rmw(16'h0103, 8'h01); m[3] = m[3] | 1;
        host.rd(16'h0103, v); chk(v, m[3]);
        inband_enable_strap_pin_i <= 1'b0;
        resetn_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        host.rd(16'h0107, v); chk(v, 8'h00);
        host.rd(16'h0100, v); chk(v, 8'h42);
        give_verdict;
    end
endmodule
